// file: design/secondary_prefetch_flow_through_ctl.v
/*
  Secondary-side prefetch limit and flow-through wait control:
  configuration registers, per-entry prefetch cap, incremental prefetch
  enable, two-entry posted write buffer and the write/read wait timers.
  Assumes all inputs are synchronous to clk_sys_i, the secondary clock,
  and that software writes even prefetch values.
*/
// The strobed register port was chosen for this implementation.
// Operation
// - Cap non-flow-through entry prefetch at limit field
// - Limit zero means 256 bytes; resets 20h
// - Reserved register bits read back zero
// - Write wait code bounds wait for initiator data
// - Write wait expiry terminates the target write
// - Write code 000 terminates at one entry
// - Write codes 1-7 hold IRDY, wait clocks
// - Read wait code bounds wait for queue space
// - Read wait expiry terminates the target read
// - Read code 000 terminates at one entry
// - Read codes 1-7 hold TRDY, wait clocks
// - Incremental count above half max disables incremental
`timescale 1ns/1ps
`include "sec_prefetch_consts.vh"

module flow_wait_timer (
  input wire clk_sys_i,
  input wire reset_i,
  input wire active_i,
  input wire low_i,
  input wire refill_i,
  input wire [2:0] code_i,
  output wire hold_o,
  output wire term_o
);

  // Wait states
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] cnt_r;
  reg [2:0] cnt_nxt;
  reg hold_r;
  reg hold_nxt;
  reg term_r;
  reg term_nxt;

  // Hold counts clocks 1 to code, then one terminate pulse
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hold_nxt = 1'b0;
    term_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (active_i && low_i && !refill_i) begin
          if (code_i == 3'h0) begin
            term_nxt = 1'b1;
            state_nxt = ST_DONE;
          end else begin
            hold_nxt = 1'b1;
            cnt_nxt = 3'h1;
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (!active_i || refill_i) begin
          state_nxt = ST_IDLE;
        end else if (cnt_r == code_i) begin
          term_nxt = 1'b1;
          state_nxt = ST_DONE;
        end else begin
          hold_nxt = 1'b1;
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      ST_DONE: begin
        if (!active_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      hold_r <= 1'b0;
      term_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
      term_r <= term_nxt;
    end
  end

  assign hold_o = hold_r;
  assign term_o = term_r;

endmodule // flow_wait_timer

module secondary_prefetch_flow_through_ctl (
  input wire clk_sys_i,
  input wire reset_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  // Prefetch allocation
  input wire pf_entry_start_i,
  input wire pf_flow_through_i,
  input wire pf_dw_take_i,
  output wire pf_allow_o,
  output wire incr_pf_en_o,
  // Posted write buffer and wait
  input wire wr_ft_active_i,
  input wire wr_in_valid_i,
  input wire [`DATA_W-1:0] wr_in_data_i,
  output wire wr_in_ready_o,
  output wire wr_out_valid_o,
  output wire [`DATA_W-1:0] wr_out_data_o,
  input wire wr_out_ready_i,
  output wire wr_irdy_hold_o,
  output wire wr_terminate_o,
  // Delayed read wait
  input wire rd_ft_active_i,
  input wire rd_q_one_left_i,
  input wire rd_space_free_i,
  output wire rd_trdy_hold_o,
  output wire rd_terminate_o
);

  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_INCR = 2'b01;
  localparam [1:0] SEL_LIMIT = 2'b10;
  localparam [1:0] SEL_FLOW = 2'b11;

  // Register select shared by the write and read paths
  function [1:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_SEC_INCR_PREFETCH: reg_sel = SEL_INCR;
        `OFS_SEC_PREFETCH_LIMIT: reg_sel = SEL_LIMIT;
        `OFS_SEC_FLOW_WAIT: reg_sel = SEL_FLOW;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // Prefetch limit in double words; zero means the 256-byte maximum
  function [6:0] pf_limit_dw;
    input [7:0] field;
    begin
      if (field[5:0] == 6'h00) begin
        pf_limit_dw = `PF_ZERO_LIMIT_DW;
      end else begin
        pf_limit_dw = {1'b0, field[5:0]};
      end
    end
  endfunction

  // Count field with bit 0 and the spare bits forced to zero
  function [7:0] even_field;
    input [7:0] wdata;
    begin
      even_field = {2'b00, wdata[`PF_FIELD_HI:`PF_FIELD_LO], 1'b0};
    end
  endfunction

  // Flow wait image with both spare bits forced to zero
  function [7:0] flow_field;
    input [7:0] wdata;
    begin
      flow_field = {1'b0, wdata[`RD_WAIT_HI:`RD_WAIT_LO], 1'b0,
                    wdata[`WR_WAIT_HI:`WR_WAIT_LO]};
    end
  endfunction

  reg [7:0] incr_pf_r;
  reg [7:0] pf_limit_r;
  reg [7:0] flow_wait_r;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg [6:0] pf_used_r;
  reg [6:0] pf_used_nxt;
  reg pf_allow_r;
  reg incr_en_r;
  reg head_valid_r;
  reg [`DATA_W-1:0] head_data_r;
  reg tail_valid_r;
  reg [`DATA_W-1:0] tail_data_r;
  reg wr_in_ready_r;
  wire [6:0] limit_dw;
  wire push;
  wire pop;
  wire wr_low;
  wire wr_hold;
  wire [1:0] addr_sel;

  assign addr_sel = reg_sel(reg_addr_i);

  // Configuration registers
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      incr_pf_r <= `RST_SEC_INCR_PREFETCH;
      pf_limit_r <= `RST_SEC_PREFETCH_LIMIT;
      flow_wait_r <= `RST_SEC_FLOW_WAIT;
    end else if (reg_wr_i) begin
      case (addr_sel)
        SEL_INCR: begin
          incr_pf_r <= even_field(reg_wdata_i);
        end
        SEL_LIMIT: begin
          pf_limit_r <= even_field(reg_wdata_i);
        end
        SEL_FLOW: begin
          flow_wait_r <= flow_field(reg_wdata_i);
        end
        default: begin
          flow_wait_r <= flow_wait_r;
        end
      endcase
    end
  end

  // Read data, valid the cycle after the strobe
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd_i) begin
      case (addr_sel)
        SEL_INCR: rdata_nxt = incr_pf_r;
        SEL_LIMIT: rdata_nxt = pf_limit_r;
        SEL_FLOW: rdata_nxt = flow_wait_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Prefetch allocation per delayed read entry
  assign limit_dw = pf_limit_dw(pf_limit_r);

  always @* begin
    pf_used_nxt = pf_used_r;
    if (pf_entry_start_i) begin
      pf_used_nxt = 7'h00;
    end else if (pf_dw_take_i && pf_used_r != 7'h7f) begin
      pf_used_nxt = pf_used_r + 7'h01;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pf_used_r <= 7'h00;
      pf_allow_r <= 1'b0;
      incr_en_r <= 1'b0;
    end else begin
      pf_used_r <= pf_used_nxt;
      pf_allow_r <= pf_flow_through_i || (pf_used_nxt < limit_dw);
      incr_en_r <= ({1'b0, incr_pf_r[5:0]} <= {1'b0, limit_dw[6:1]});
    end
  end

  // Two-entry posted write buffer
  assign push = wr_in_valid_i && !tail_valid_r;
  assign pop = head_valid_r && wr_out_ready_i && !wr_hold;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_in_ready_r <= 1'b1;
      head_valid_r <= 1'b0;
      tail_valid_r <= 1'b0;
      head_data_r <= {`DATA_W{1'b0}};
      tail_data_r <= {`DATA_W{1'b0}};
    end else begin
      if (pop) begin
        if (tail_valid_r) begin
          head_data_r <= tail_data_r;
          if (push) begin
            tail_data_r <= wr_in_data_i;
          end else begin
            tail_valid_r <= 1'b0;
            wr_in_ready_r <= 1'b1;
          end
        end else if (push) begin
          head_data_r <= wr_in_data_i;
        end else begin
          head_valid_r <= 1'b0;
        end
      end else if (push) begin
        if (head_valid_r) begin
          tail_data_r <= wr_in_data_i;
          tail_valid_r <= 1'b1;
          wr_in_ready_r <= 1'b0;
        end else begin
          head_data_r <= wr_in_data_i;
          head_valid_r <= 1'b1;
        end
      end
    end
  end

  // Queue nearly empty: only the head entry is left
  assign wr_low = head_valid_r && !tail_valid_r;

  flow_wait_timer u_wr_wait (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .active_i(wr_ft_active_i),
    .low_i(wr_low),
    .refill_i(push),
    .code_i(flow_wait_r[`WR_WAIT_HI:`WR_WAIT_LO]),
    .hold_o(wr_hold),
    .term_o(wr_terminate_o)
  );

  flow_wait_timer u_rd_wait (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .active_i(rd_ft_active_i),
    .low_i(rd_q_one_left_i),
    .refill_i(rd_space_free_i),
    .code_i(flow_wait_r[`RD_WAIT_HI:`RD_WAIT_LO]),
    .hold_o(rd_trdy_hold_o),
    .term_o(rd_terminate_o)
  );

  assign reg_rdata_o = rdata_r;
  assign pf_allow_o = pf_allow_r;
  assign incr_pf_en_o = incr_en_r;
  assign wr_in_ready_o = wr_in_ready_r;
  assign wr_out_valid_o = head_valid_r;
  assign wr_out_data_o = head_data_r;
  assign wr_irdy_hold_o = wr_hold;

endmodule // secondary_prefetch_flow_through_ctl

// file: inc/sec_prefetch_consts.vh
/*
  Register offsets, field positions, reset values and limits for the
  secondary prefetch limit and flow-through wait control block.
  Assumes 8-bit configuration byte addressing at the printed offsets.
*/
`ifndef SEC_PREFETCH_CONSTS_VH
`define SEC_PREFETCH_CONSTS_VH

// Register offsets
`define OFS_SEC_INCR_PREFETCH 8'h4b
`define OFS_SEC_PREFETCH_LIMIT 8'h4d
`define OFS_SEC_FLOW_WAIT 8'h4e

// Reset values
`define RST_SEC_INCR_PREFETCH 8'h10
`define RST_SEC_PREFETCH_LIMIT 8'h20
`define RST_SEC_FLOW_WAIT 8'h00

// Field positions
`define PF_FIELD_HI 5
`define PF_FIELD_LO 1
`define WR_WAIT_HI 2
`define WR_WAIT_LO 0
`define RD_WAIT_HI 6
`define RD_WAIT_LO 4

// Prefetch limit for a field of zero: 256 bytes as double words
`define PF_ZERO_LIMIT_DW 7'h40

// Buffer data width
`define DATA_W 32

`endif

// file: bench/sec_pf_chk.sv
/* Port checker for the prefetch and flow wait control.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module sec_pf_chk (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire pf_flow_through_i,
  input wire pf_allow_o,
  input wire wr_irdy_hold_o,
  input wire wr_terminate_o,
  input wire rd_ft_active_i,
  input wire rd_trdy_hold_o,
  input wire rd_terminate_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_lim; reg_rd_i && reg_addr_i == 8'h4d |=> (reg_rdata_o & 8'hc1) == 8'h00; endproperty
  a_lim: assert property (p_lim) else $error("limit spare bits");
  property p_flw; reg_rd_i && reg_addr_i == 8'h4e |=> (reg_rdata_o & 8'h88) == 8'h00; endproperty
  a_flw: assert property (p_flw) else $error("wait spare bits");
  property p_ft; pf_flow_through_i |=> pf_allow_o; endproperty
  a_ft: assert property (p_ft) else $error("flow entry capped");
  property p_wh; $rose(wr_irdy_hold_o) |-> ##[1:7] !wr_irdy_hold_o; endproperty
  a_wh: assert property (p_wh) else $error("write wait long");
  property p_rh; $rose(rd_trdy_hold_o) |-> ##[1:7] !rd_trdy_hold_o; endproperty
  a_rh: assert property (p_rh) else $error("read wait long");
  property p_wt; wr_terminate_o |-> !wr_irdy_hold_o ##1 !wr_terminate_o; endproperty
  a_wt: assert property (p_wt) else $error("write end bad");
  property p_rt; rd_terminate_o |-> !rd_trdy_hold_o ##1 !rd_terminate_o; endproperty
  a_rt: assert property (p_rt) else $error("read end bad");
  property p_ra; rd_terminate_o |-> $past(rd_ft_active_i); endproperty
  a_ra: assert property (p_ra) else $error("read end idle");
  c_wt: cover property (wr_terminate_o);
  c_rt: cover property (rd_terminate_o);
  c_cap: cover property ($fell(pf_allow_o));
endmodule // sec_pf_chk
bind secondary_prefetch_flow_through_ctl sec_pf_chk chk (.*);

// file: bench/wr_target_model.sv
/* Target side of the posted write path.
   Assumes stall_i changes only after a clock edge. */
`timescale 1ns/1ps
module wr_target_model (
  input wire stall_i,
  output wire ready_o
);
  // Target may stall in any cycle
  assign ready_o = !stall_i;
endmodule // wr_target_model

// file: bench/secondary_prefetch_flow_through_ctl_test.sv
/* Self-checking bench for the prefetch and flow wait control.
   Assumes design, target model and checker are compiled first. */
`timescale 1ns/1ps
module secondary_prefetch_flow_through_ctl_test;
  reg clk_sys_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, stall = 0, fill = 0;
  reg pf_entry_start_i = 0, pf_flow_through_i = 0, pf_dw_take_i = 0, wr_in_valid_i = 0;
  reg wr_ft_active_i = 0, rd_ft_active_i = 0, rd_q_one_left_i = 0, rd_space_free_i = 0;
  reg [7:0] reg_addr_i = 0, reg_wdata_i = 0;
  reg [31:0] wr_in_data_i = 0;
  wire [7:0] reg_rdata_o;
  wire [31:0] wr_out_data_o;
  wire pf_allow_o, incr_pf_en_o, wr_in_ready_o, wr_out_valid_o, wr_out_ready_i;
  wire wr_irdy_hold_o, wr_terminate_o, rd_trdy_hold_o, rd_terminate_o;
  integer fail_count = 0, samples_checked = 0, i, k, inc, hw, hr, tw, tr;
  reg [31:0] q [$];
  always #25 clk_sys_i = !clk_sys_i;
  secondary_prefetch_flow_through_ctl dut (.*);
  wr_target_model tgt (.stall_i(stall), .ready_o(wr_out_ready_i));
  task t;
    @(posedge clk_sys_i);
  endtask
  task chk(input [47:0] n, input [31:0] s, e); begin
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value %0s expected %h seen %h", n, e, s);
    end
  end endtask
  task results; begin
    $display("checks %0d wrong %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end endtask
  task rg(input w, input [7:0] a, d); begin
    t;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    t;
    reg_wr_i <= 0;
    reg_rd_i <= 0;
    #1 if (!w) chk("rdata", reg_rdata_o, d);
  end endtask
  // New entry takes n+2 dwords, allow checked on the first n+1, then flow-through lifts the cap
  task pf(input [7:0] f, input integer n); begin
    rg(1, 8'h4d, f);
    t;
    pf_entry_start_i <= 1;
    t;
    pf_entry_start_i <= 0;
    pf_dw_take_i <= 1;
    for (i = 1; i <= n + 1; i = i + 1) begin
      t;
      #1 chk("allow", pf_allow_o, i < n);
    end
    t;
    pf_dw_take_i <= 0;
    pf_flow_through_i <= 1;
    t;
    pf_flow_through_i <= 0;
    #1 chk("allow", pf_allow_o, 1);
    chk("incr", incr_pf_en_o, inc <= n / 2);
  end endtask
  // Both wait timers; rf refills in mid-wait
  task wt(input [2:0] c, input rf); begin
    rg(1, 8'h4e, {1'b0, c, 1'b0, c});
    t;
    {wr_ft_active_i, rd_ft_active_i, rd_q_one_left_i, wr_in_valid_i} <= 4'hf;
    wr_in_data_i <= $urandom;
    t;
    wr_in_valid_i <= 0;
    #1 {hw, hr, tw, tr} = 0;
    repeat (2) t;
    wr_in_valid_i <= rf;
    rd_space_free_i <= rf;
    t;
    wr_in_valid_i <= 0;
    rd_space_free_i <= 0;
    if (rf) {wr_ft_active_i, rd_ft_active_i, rd_q_one_left_i} <= 3'h0;
    repeat (10) t;
    #1 chk("wterm", tw, !rf);
    chk("rterm", tr, !rf);
    if (!rf) chk("whold", hw, c);
    if (!rf) chk("rhold", hr, c);
    t;
    {wr_ft_active_i, rd_ft_active_i, rd_q_one_left_i} <= 3'h0;
    repeat (4) t;
  end endtask
  always @(posedge clk_sys_i) begin
    stall <= fill || $urandom % 2;
    hw = hw + wr_irdy_hold_o;
    hr = hr + rd_trdy_hold_o;
    tw = tw + wr_terminate_o;
    tr = tr + rd_terminate_o;
    if (wr_in_valid_i && wr_in_ready_o)
      q.push_back(wr_in_data_i);
    if (wr_out_valid_o && wr_out_ready_i && !wr_irdy_hold_o)
      chk("wdata", wr_out_data_o, q.pop_front());
  end
  initial begin
    #300000;
    fail_count = fail_count + 1;
    results;
  end
  initial begin
    i = $urandom(32'h98e5297d);
    inc = 16;
    repeat (16) t;
    reset_i <= 0;
    rg(0, 8'h4b, 8'h10);
    rg(0, 8'h4d, 8'h20);
    rg(0, 8'h4e, 8'h00);
    rg(0, 8'h4c, 8'h00);
    rg(1, 8'h4d, 8'hff);
    rg(0, 8'h4d, 8'h3e);
    t;
    #1 chk("rdidle", reg_rdata_o, 8'h00);
    rg(1, 8'h4e, 8'hff);
    rg(0, 8'h4e, 8'h77);
    $display("regs done");
    pf(8'h02, 2);
    pf(8'h3e, 62);
    pf(8'h00, 64);
    pf(8'h20, 32);
    rg(1, 8'h4b, 8'h12);
    inc = 18;
    pf(8'h20, 32);
    $display("prefetch done");
    for (k = 0; k < 8; k = k + 1)
      wt(k[2:0], 0);
    wt(3'h7, 1);
    $display("wait done");
    fill = 1;
    t;
    wr_in_valid_i <= 1;
    for (i = 0; i < 3; i = i + 1) begin
      wr_in_data_i <= $urandom;
      t;
    end
    #1 chk("ready", wr_in_ready_o, 0);
    chk("ovalid", wr_out_valid_o, 1);
    fill = 0;
    while (wr_in_ready_o !== 1)
      t;
    wr_in_valid_i <= 0;
    repeat (20) t;
    #1 chk("left", q.size(), 0);
    chk("ovalid", wr_out_valid_o, 0);
    $display("buffer done");
    results;
  end
endmodule // secondary_prefetch_flow_through_ctl_test
